//--- hdl/portb_pkg.sv
package portb_pkg;

  localparam int          CLK_HZ       = 125000000;
  localparam int          SLOW_CLK_HZ  = 16000;
  localparam int          CORE_SLOW_HZ = 32000;
  localparam int          DIV_W        = 12;
  // half periods, rounded down
  localparam logic [11:0] SLOW_HALF_CYC = 12'(CLK_HZ / (2 * SLOW_CLK_HZ));
  localparam logic [11:0] CORE_SLOW_HALF_CYC =
    12'(CLK_HZ / (2 * CORE_SLOW_HZ));
  localparam logic [11:0] CORE_FAST_HALF_CYC = 12'h002; // fast clock / 4
  localparam logic [11:0] CNT_ONE = 12'h001;

  // register byte offsets
  localparam logic [11:0] OUT_OFS    = 12'h000;
  localparam logic [11:0] IN_OFS     = 12'h004;
  localparam logic [11:0] DIR_OFS    = 12'h008;
  localparam logic [11:0] OD_OFS     = 12'h00C;
  localparam logic [11:0] PU_OFS     = 12'h010;
  localparam logic [11:0] ANA_OFS    = 12'h014;
  localparam logic [11:0] FUNC_OFS   = 12'h018;
  localparam logic [11:0] LINE_OFS   = 12'h01C;

  // function control bits
  localparam int FN_PWM0 = 0;
  localparam int FN_PWM1 = 1;
  localparam int FN_SLOW = 2;
  localparam int FN_CORE = 3;
  localparam int FN_CSEL = 4;
  localparam int FN_SYNC = 5;
  localparam int FN_TX   = 6;
  localparam int FN_RX   = 7;
  // line value bits
  localparam int LN_0 = 0;
  localparam int LN_1 = 1;
  // pin positions
  localparam int PIN_PWM0  = 0;
  localparam int PIN_PWM1  = 1;
  localparam int PIN_CORE  = 2;
  localparam int PIN_SLOW  = 3;
  localparam int PIN_LINE0 = 4;
  localparam int PIN_LINE1 = 5;
  localparam int PIN_TX    = 6;
  localparam int PIN_RX    = 7;

  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONES = 8'hFF;
  localparam logic [7:0] PU_RST    = 8'hFF;
  localparam logic [7:0] PU_EN_RST = 8'hFD; // pin 1 pulled down in reset

  typedef struct packed {
    logic [7:0]       out;
    logic [7:0]       dir;
    logic [7:0]       od;
    logic [7:0]       pu;
    logic [7:0]       ana;
    logic [7:0]       func;
    logic [7:0]       line;
    logic [7:0]       pin_s1;
    logic [7:0]       pin_s2;
    logic             por_s1;
    logic             por_s2;
    logic [DIV_W-1:0] slow_cnt;
    logic [DIV_W-1:0] core_cnt;
    logic             slow_clk;
    logic             core_clk;
    logic [7:0]       pad_out;
    logic [7:0]       pad_oe_n;
    logic [7:0]       pullup_en;
    logic [7:0]       input_buf_en;
    logic [7:0]       analog_en;
    logic             pulldown1;
    logic             rx_data;
    logic             line0_in;
    logic             line1_in;
    logic [31:0]      prdata;
  } port_state_s;

endpackage

//--- hdl/portb_io.sv
`timescale 1ns/100ps
`default_nettype none
module portb_io
  import portb_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  pad_in,
  output logic [7:0]       pad_out,
  output logic [7:0]       pad_oe_n,
  output logic [7:0]       pad_pullup_en,
  output logic             pad1_pulldown_en,
  output logic [7:0]       pad_input_buf_en,
  output logic [7:0]       pad_analog_en,
  input  wire logic        por_active,
  input  wire logic        pwm0_out,
  input  wire logic        pwm1_out,
  input  wire logic        async_tx_data,
  output logic             async_rx_data,
  input  wire logic        sync_line0_is_output,
  input  wire logic        sync_line1_is_output,
  output logic             sync_line0_in,
  output logic             sync_line1_in
);

  port_state_s state_ff;
  port_state_s nxt_state;

  // true for the eight word-aligned register slots
  function automatic logic addr_ok(input logic [11:0] a);
    addr_ok = (a <= LINE_OFS) && (a[1:0] == 2'h0);
  endfunction

  // divider wrap test, tolerant of a limit that shrinks mid-count
  function automatic logic div_wrap(input logic [DIV_W-1:0] cnt,
                                    input logic [DIV_W-1:0] half);
    div_wrap = (cnt >= half - CNT_ONE);
  endfunction

  // next-state logic: bus, dividers, synchronisers and pin mux
  always_comb begin
    logic [7:0]       fn_on;
    logic [7:0]       fn_dat;
    logic [7:0]       fn_dir;
    logic [7:0]       fn_od;
    logic [7:0]       e_dir;
    logic [7:0]       e_dat;
    logic [7:0]       e_od;
    logic [7:0]       drive;
    logic [DIV_W-1:0] core_half;
    logic [31:0]      rd;
    fn_on     = BYTE_ZERO;
    fn_dat    = BYTE_ZERO;
    fn_dir    = BYTE_ZERO;
    fn_od     = BYTE_ZERO;
    e_dir     = BYTE_ZERO;
    e_dat     = BYTE_ZERO;
    e_od      = BYTE_ZERO;
    drive     = BYTE_ZERO;
    core_half = CORE_FAST_HALF_CYC;
    rd        = 32'h0000_0000;
    nxt_state = state_ff;

    // two-flop synchronisers for pins and power-on reset
    nxt_state.pin_s1 = pad_in;
    nxt_state.pin_s2 = state_ff.pin_s1;
    nxt_state.por_s1 = por_active;
    nxt_state.por_s2 = state_ff.por_s1;

    // 16 kHz square wave
    if (div_wrap(state_ff.slow_cnt, SLOW_HALF_CYC)) begin
      nxt_state.slow_cnt = '0;
      nxt_state.slow_clk = ~state_ff.slow_clk;
    end else begin
      nxt_state.slow_cnt = state_ff.slow_cnt + CNT_ONE;
    end

    // core clock image: fast/4 or 32 kHz per select
    if (state_ff.func[FN_CSEL]) begin
      core_half = CORE_SLOW_HALF_CYC;
    end
    if (div_wrap(state_ff.core_cnt, core_half)) begin
      nxt_state.core_cnt = '0;
      nxt_state.core_clk = ~state_ff.core_clk;
    end else begin
      nxt_state.core_cnt = state_ff.core_cnt + CNT_ONE;
    end

    // register writes take effect in the access phase
    if (psel && penable && pwrite && addr_ok(paddr)) begin
      case (paddr)
        OUT_OFS:  nxt_state.out  = pwdata[7:0];
        DIR_OFS:  nxt_state.dir  = pwdata[7:0];
        OD_OFS:   nxt_state.od   = pwdata[7:0];
        PU_OFS:   nxt_state.pu   = pwdata[7:0];
        ANA_OFS:  nxt_state.ana  = pwdata[7:0];
        FUNC_OFS: nxt_state.func = pwdata[7:0];
        LINE_OFS: nxt_state.line = pwdata[7:0];
        default:  nxt_state.out  = state_ff.out; // input is read-only
      endcase
    end

    // read data is captured in the setup phase
    case (paddr)
      OUT_OFS:  rd[7:0] = state_ff.out;
      IN_OFS:   rd[7:0] = state_ff.pin_s2 & ~state_ff.ana;
      DIR_OFS:  rd[7:0] = state_ff.dir;
      OD_OFS:   rd[7:0] = state_ff.od;
      PU_OFS:   rd[7:0] = state_ff.pu;
      ANA_OFS:  rd[7:0] = state_ff.ana;
      FUNC_OFS: rd[7:0] = state_ff.func;
      LINE_OFS: rd[7:0] = state_ff.line;
      default:  rd      = 32'h0000_0000;
    endcase
    if (psel && !penable && !pwrite) begin
      nxt_state.prdata = rd;
    end

    // peripheral function overlay, per pin
    fn_on[PIN_PWM0]   = state_ff.func[FN_PWM0];
    fn_dat[PIN_PWM0]  = pwm0_out;
    fn_dir[PIN_PWM0]  = state_ff.dir[PIN_PWM0];
    fn_od[PIN_PWM0]   = state_ff.od[PIN_PWM0];
    fn_on[PIN_PWM1]   = state_ff.func[FN_PWM1];
    fn_dat[PIN_PWM1]  = pwm1_out;
    fn_dir[PIN_PWM1]  = state_ff.dir[PIN_PWM1];
    fn_od[PIN_PWM1]   = state_ff.od[PIN_PWM1];
    fn_on[PIN_CORE]   = state_ff.func[FN_CORE];
    fn_dat[PIN_CORE]  = state_ff.core_clk;
    fn_dir[PIN_CORE]  = state_ff.dir[PIN_CORE];
    fn_od[PIN_CORE]   = state_ff.od[PIN_CORE];
    fn_on[PIN_SLOW]   = state_ff.func[FN_SLOW];
    fn_dat[PIN_SLOW]  = state_ff.slow_clk;
    fn_dir[PIN_SLOW]  = state_ff.dir[PIN_SLOW];
    fn_od[PIN_SLOW]   = state_ff.od[PIN_SLOW];
    fn_on[PIN_LINE0]  = state_ff.func[FN_SYNC];
    fn_dat[PIN_LINE0] = state_ff.line[LN_0];
    fn_dir[PIN_LINE0] = sync_line0_is_output;
    fn_od[PIN_LINE0]  = 1'b1;
    fn_on[PIN_LINE1]  = state_ff.func[FN_SYNC];
    fn_dat[PIN_LINE1] = state_ff.line[LN_1];
    fn_dir[PIN_LINE1] = sync_line1_is_output;
    fn_od[PIN_LINE1]  = 1'b1;
    fn_on[PIN_TX]     = state_ff.func[FN_TX];
    fn_dat[PIN_TX]    = async_tx_data;
    fn_dir[PIN_TX]    = 1'b1;
    fn_od[PIN_TX]     = state_ff.od[PIN_TX];
    fn_on[PIN_RX]     = state_ff.func[FN_RX];
    fn_dat[PIN_RX]    = 1'b0;
    fn_dir[PIN_RX]    = 1'b0;
    fn_od[PIN_RX]     = state_ff.od[PIN_RX];

    // function beats digital set-up, analog beats both
    e_dir = (fn_on & fn_dir) | (~fn_on & state_ff.dir);
    e_dat = (fn_on & fn_dat) | (~fn_on & state_ff.out);
    e_od  = (fn_on & fn_od) | (~fn_on & state_ff.od);
    drive = e_dir & ~(e_od & e_dat) & ~state_ff.ana;
    nxt_state.pad_oe_n     = ~drive;
    nxt_state.pad_out      = e_dat & ~e_od & ~state_ff.ana;
    nxt_state.pullup_en    = state_ff.pu & ~state_ff.ana
                             & (~e_dir | (e_od & e_dat));
    nxt_state.pulldown1    = state_ff.por_s2;
    if (state_ff.por_s2) begin
      nxt_state.pullup_en[PIN_PWM1] = 1'b0;
    end
    nxt_state.input_buf_en = ~state_ff.ana;
    nxt_state.analog_en    = state_ff.ana;

    // function inputs back to the peripherals
    nxt_state.rx_data  = state_ff.pin_s2[PIN_RX] & state_ff.func[FN_RX]
                         & ~state_ff.ana[PIN_RX];
    nxt_state.line0_in = state_ff.pin_s2[PIN_LINE0];
    nxt_state.line1_in = state_ff.pin_s2[PIN_LINE1];
  end

  // state register, set to its reset values by the port reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff              <= '0;
      state_ff.pu           <= PU_RST;
      state_ff.por_s1       <= 1'b1;
      state_ff.por_s2       <= 1'b1;
      state_ff.pad_oe_n     <= BYTE_ONES;
      state_ff.pullup_en    <= PU_EN_RST;
      state_ff.pulldown1    <= 1'b1;
      state_ff.input_buf_en <= BYTE_ONES;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // outputs
  assign prdata           = state_ff.prdata;
  assign pready           = 1'b1;
  assign pslverr          = psel && penable && !addr_ok(paddr);
  assign pad_out          = state_ff.pad_out;
  assign pad_oe_n         = state_ff.pad_oe_n;
  assign pad_pullup_en    = state_ff.pullup_en;
  assign pad1_pulldown_en = state_ff.pulldown1;
  assign pad_input_buf_en = state_ff.input_buf_en;
  assign pad_analog_en    = state_ff.analog_en;
  assign async_rx_data    = state_ff.rx_data;
  assign sync_line0_in    = state_ff.line0_in;
  assign sync_line1_in    = state_ff.line1_in;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pwm0_pin_drive: assert property (
    (state_ff.func[FN_PWM0] && !state_ff.ana[PIN_PWM0]
     && state_ff.dir[PIN_PWM0] && !state_ff.od[PIN_PWM0])
    |=> (!pad_oe_n[PIN_PWM0] && pad_out[PIN_PWM0] == $past(pwm0_out)))
    else $error("pin 0 does not follow pwm channel 0");

  a_slow_clk_pin: assert property (
    (state_ff.func[FN_SLOW] && !state_ff.ana[PIN_SLOW]
     && state_ff.dir[PIN_SLOW] && !state_ff.od[PIN_SLOW])
    |=> pad_out[PIN_SLOW] == $past(state_ff.slow_clk))
    else $error("pin 3 does not carry the slow clock");

  a_core_clk_pin: assert property (
    (state_ff.func[FN_CORE] && !state_ff.ana[PIN_CORE]
     && state_ff.dir[PIN_CORE] && !state_ff.od[PIN_CORE])
    |=> pad_out[PIN_CORE] == $past(state_ff.core_clk))
    else $error("pin 2 does not carry the core clock");

  a_core_clk_rate: assert property (
    (state_ff.core_cnt == (state_ff.func[FN_CSEL] ? CORE_SLOW_HALF_CYC
                           : CORE_FAST_HALF_CYC) - CNT_ONE)
    |=> $changed(state_ff.core_clk) ##1 $stable(state_ff.core_clk))
    else $error("core clock half period is wrong");

  a_sync_line_od: assert property (
    (state_ff.func[FN_SYNC] && !state_ff.ana[PIN_LINE0])
    |=> (!pad_out[PIN_LINE0] && pad_oe_n[PIN_LINE0]
         == !($past(sync_line0_is_output) && !$past(state_ff.line[LN_0]))))
    else $error("pin 4 is not an open-drain serial line");

  a_tx_pin_drive: assert property (
    (state_ff.func[FN_TX] && !state_ff.ana[PIN_TX] && !state_ff.od[PIN_TX])
    |=> (!pad_oe_n[PIN_TX] && pad_out[PIN_TX] == $past(async_tx_data)))
    else $error("pin 6 does not transmit");

  a_rx_pin_input: assert property (
    (state_ff.func[FN_RX] && !state_ff.ana[PIN_RX])
    |=> (pad_oe_n[PIN_RX]
         && async_rx_data == $past(state_ff.pin_s2[PIN_RX])))
    else $error("pin 7 is not a receive input");

  a_plain_input_hiz: assert property (
    (state_ff.dir == BYTE_ZERO && state_ff.func == BYTE_ZERO)
    |=> pad_oe_n == BYTE_ONES)
    else $error("input-only pin is driven");

  a_input_read_back: assert property (
    (psel && !penable && !pwrite && paddr == IN_OFS)
    |=> prdata[7:0] == $past(state_ff.pin_s2 & ~state_ff.ana))
    else $error("input register does not show pin levels");

  a_output_data_pin: assert property (
    (state_ff.dir[PIN_RX] && !state_ff.func[FN_RX] && !state_ff.ana[PIN_RX])
    |=> (pad_oe_n[PIN_RX] == $past(state_ff.od[PIN_RX]
                                  && state_ff.out[PIN_RX])
         && pad_out[PIN_RX] == $past(!state_ff.od[PIN_RX]
                                     && state_ff.out[PIN_RX])))
    else $error("pin 7 output data or open-drain wrong");

  a_pullup_gate: assert property (
    1'b1 |=> (pad_pullup_en & ~$past(state_ff.pu)) == BYTE_ZERO
             && (pad_pullup_en & ~pad_oe_n) == BYTE_ZERO)
    else $error("pull-up on without its bit or on a driven pin");

  a_por_pulldown: assert property (
    state_ff.por_s2 |=> (pad1_pulldown_en && !pad_pullup_en[PIN_PWM1]))
    else $error("pin 1 not pulled down in power-on reset");

  a_analog_priority: assert property (
    1'b1 |=> (pad_input_buf_en == ~$past(state_ff.ana)
              && pad_analog_en == $past(state_ff.ana)
              && (~pad_oe_n & $past(state_ff.ana)) == BYTE_ZERO))
    else $error("analog pin still digital");

  a_pwm1_pin_drive: assert property (
    (state_ff.func[FN_PWM1] && !state_ff.ana[PIN_PWM1]
     && state_ff.dir[PIN_PWM1] && !state_ff.od[PIN_PWM1])
    |=> (!pad_oe_n[PIN_PWM1] && pad_out[PIN_PWM1] == $past(pwm1_out)))
    else $error("pin 1 does not follow pwm channel 1");

  a_slow_clk_rate: assert property (
    (state_ff.slow_cnt == SLOW_HALF_CYC - CNT_ONE)
    |=> $changed(state_ff.slow_clk) ##1 $stable(state_ff.slow_clk))
    else $error("slow clock half period is wrong");

  a_sync_line1_od: assert property (
    (state_ff.func[FN_SYNC] && !state_ff.ana[PIN_LINE1])
    |=> (!pad_out[PIN_LINE1] && pad_oe_n[PIN_LINE1]
         == !($past(sync_line1_is_output) && !$past(state_ff.line[LN_1]))))
    else $error("pin 5 is not an open-drain serial line");

  a_dir_write_lands: assert property (
    (psel && penable && pwrite && paddr == DIR_OFS)
    |=> state_ff.dir == $past(pwdata[7:0]))
    else $error("direction write did not land");

  a_input_write_ignored: assert property (
    (psel && penable && pwrite && paddr == IN_OFS)
    |=> $stable({state_ff.out, state_ff.dir, state_ff.od, state_ff.pu,
                 state_ff.ana, state_ff.func, state_ff.line}))
    else $error("write to the input register changed a register");

  a_unmapped_slverr: assert property (
    (psel && penable && paddr > LINE_OFS) |-> pslverr)
    else $error("unmapped access gave no error");

  a_pulldown_release: assert property (
    !state_ff.por_s2 |=> !pad1_pulldown_en)
    else $error("pin 1 still pulled down after power-on reset");

  a_analog_no_drive: assert property (
    1'b1 |=> (pad_out & $past(state_ff.ana)) == BYTE_ZERO)
    else $error("analog pin still has a drive level");

  c_pwm_active: cover property (
    state_ff.func[FN_PWM0] && !pad_oe_n[PIN_PWM0] ##1 $changed(pwm0_out));
  c_sync_mode: cover property (
    state_ff.func[FN_SYNC] && !pad_oe_n[PIN_LINE0]);
  c_analog_pin: cover property (pad_analog_en != BYTE_ZERO);
  c_core_slow: cover property (
    state_ff.func[FN_CSEL] && $rose(state_ff.core_clk));
  c_tx_mode: cover property (
    state_ff.func[FN_TX] && !pad_oe_n[PIN_TX]);

endmodule
`default_nettype wire

//--- bench/pin_env.sv
`timescale 1ns/100ps
`default_nettype none
// far side of the port: device drive, outside sources and pulls on each pin
module pin_env (
  input  wire logic       pclk,
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe_n,
  input  wire logic [7:0] pad_pullup_en,
  input  wire logic       pad1_pulldown_en,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic [7:0]      pad_in
);
  logic float_ff = 1'b0;

  // a pin with nothing on it wobbles every cycle
  always @(posedge pclk) float_ff <= ~float_ff;

  // wire level: device drive first, then outside source, then pulls
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (!pad_oe_n[i]) pad_in[i] = pad_out[i];
      else if (ext_en[i]) pad_in[i] = ext_val[i];
      else if (pad_pullup_en[i]) pad_in[i] = 1'b1;
      else if (i == 1 && pad1_pulldown_en) pad_in[i] = 1'b0;
      else pad_in[i] = float_ff;
    end
  end
endmodule
`default_nettype wire

//--- bench/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench
  import portb_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        por_active, pwm0_out, pwm1_out, async_tx_data, async_rx_data;
  logic        sync_line0_is_output, sync_line1_is_output, pad1_pulldown_en;
  logic        sync_line0_in, sync_line1_in;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  pad_in, pad_out, pad_oe_n, pad_pullup_en, pad_input_buf_en;
  logic [7:0]  pad_analog_en, ext_en, ext_val;
  int          n_mismatch, tests_run, cyc, hp;

  portb_io DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pullup_en(pad_pullup_en),
    .pad1_pulldown_en(pad1_pulldown_en),
    .pad_input_buf_en(pad_input_buf_en), .pad_analog_en(pad_analog_en),
    .por_active(por_active), .pwm0_out(pwm0_out), .pwm1_out(pwm1_out),
    .async_tx_data(async_tx_data), .async_rx_data(async_rx_data),
    .sync_line0_is_output(sync_line0_is_output),
    .sync_line1_is_output(sync_line1_is_output),
    .sync_line0_in(sync_line0_in), .sync_line1_in(sync_line1_in));

  pin_env pins (.pclk(pclk), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .pad_pullup_en(pad_pullup_en), .pad1_pulldown_en(pad1_pulldown_en),
    .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));

  // clock and hang guard
  initial pclk = 1'b0;
  always #4 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      summarize;
    end
  end

  task summarize;
    $display("checks=%0d mismatches=%0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one apb transfer: setup, then access until pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  task settle;
    repeat (6) @(posedge pclk);
  endtask

  // cycles between pin toggles, after two warm-up intervals
  task half_period(input int idx, output int n);
    logic v;
    for (int j = 0; j < 3; j++) begin
      v = pad_out[idx];
      n = 0;
      while (pad_out[idx] === v && n < 9000) begin
        @(posedge pclk);
        n++;
      end
    end
  endtask

  task t_reset;
    check(32'(pad_oe_n), 32'hFF);
    check(32'(pad1_pulldown_en), 32'h1);
    check(32'(pad_pullup_en), 32'hFD);
    presetn <= 1'b1;
    settle;
    check(32'(pad1_pulldown_en), 32'h1);
    por_active <= 1'b0;
    settle;
    check(32'(pad1_pulldown_en), 32'h0);
    check(32'(pad_pullup_en), 32'hFF);
    rd_chk(OUT_OFS, 32'h0);
    rd_chk(DIR_OFS, 32'h0);
    rd_chk(OD_OFS, 32'h0);
    rd_chk(PU_OFS, 32'hFF);
    rd_chk(ANA_OFS, 32'h0);
    rd_chk(FUNC_OFS, 32'h0);
    rd_chk(IN_OFS, 32'hFF);
    $display("test reset done");
  endtask

  task t_drive;
    apb(1'b1, DIR_OFS, 32'hFF);
    apb(1'b1, OUT_OFS, 32'hA5);
    settle;
    check(32'(pad_oe_n), 32'h0);
    check(32'(pad_out), 32'hA5);
    check(32'(pad_pullup_en), 32'h0);
    rd_chk(IN_OFS, 32'hA5);
    apb(1'b1, IN_OFS, 32'h00);
    rd_chk(IN_OFS, 32'hA5);
    apb(1'b0, 12'h020, 32'h0);
    check(32'(err), 32'h1);
    apb(1'b1, OD_OFS, 32'hFF);
    settle;
    check(32'(pad_oe_n), 32'hA5);
    check(32'(pad_out), 32'h0);
    check(32'(pad_pullup_en), 32'hA5);
    ext_en <= 8'h01;
    settle;
    rd_chk(IN_OFS, 32'hA4);
    apb(1'b1, DIR_OFS, 32'h0);
    apb(1'b1, OD_OFS, 32'h0);
    ext_en <= 8'hFF;
    ext_val <= 8'h3C;
    settle;
    check(32'(pad_oe_n), 32'hFF);
    check(32'(pad_pullup_en), 32'hFF);
    rd_chk(IN_OFS, 32'h3C);
    ext_en <= 8'h00;
    $display("test drive done");
  endtask

  task t_func;
    apb(1'b1, DIR_OFS, 32'h0F);
    apb(1'b1, OUT_OFS, 32'h0);
    pwm0_out <= 1'b1;
    apb(1'b1, FUNC_OFS, 32'h03);
    settle;
    check(32'(pad_out[1:0]), 32'h1);
    pwm0_out <= 1'b0;
    pwm1_out <= 1'b1;
    settle;
    check(32'(pad_out[1:0]), 32'h2);
    apb(1'b1, FUNC_OFS, 32'h08);
    half_period(PIN_CORE, hp);
    check(32'(hp), 32'(CORE_FAST_HALF_CYC));
    apb(1'b1, FUNC_OFS, 32'h18);
    half_period(PIN_CORE, hp);
    check(32'(hp), 32'(CORE_SLOW_HALF_CYC));
    apb(1'b1, FUNC_OFS, 32'h04);
    half_period(PIN_SLOW, hp);
    check(32'(hp), 32'(SLOW_HALF_CYC));
    $display("test func done");
  endtask

  task t_serial;
    apb(1'b1, DIR_OFS, 32'hB0);
    apb(1'b1, OUT_OFS, 32'h30);
    sync_line0_is_output <= 1'b1;
    sync_line1_is_output <= 1'b1;
    apb(1'b1, LINE_OFS, 32'h01);
    apb(1'b1, PU_OFS, 32'hFF);
    apb(1'b1, FUNC_OFS, 32'h20);
    settle;
    check(32'(pad_oe_n[5:4]), 32'h1);
    check(32'(pad_out[5:4]), 32'h0);
    check(32'(sync_line0_in), 32'h1);
    check(32'(sync_line1_in), 32'h0);
    sync_line0_is_output <= 1'b0;
    ext_en <= 8'h10;
    ext_val <= 8'h00;
    apb(1'b1, LINE_OFS, 32'h00);
    settle;
    check(32'(pad_oe_n[4]), 32'h1);
    check(32'(sync_line0_in), 32'h0);
    async_tx_data <= 1'b1;
    ext_en <= 8'h80;
    apb(1'b1, FUNC_OFS, 32'hC0);
    settle;
    check(32'(pad_oe_n[7:6]), 32'h2);
    check(32'(pad_out[6]), 32'h1);
    check(32'(async_rx_data), 32'h0);
    async_tx_data <= 1'b0;
    ext_val <= 8'h80;
    settle;
    check(32'(pad_out[6]), 32'h0);
    check(32'(async_rx_data), 32'h1);
    $display("test serial done");
  endtask

  task t_analog;
    apb(1'b1, DIR_OFS, 32'h80);
    ext_en <= 8'h00;
    apb(1'b1, ANA_OFS, 32'hF0);
    settle;
    check(32'(pad_analog_en), 32'hF0);
    check(32'(pad_input_buf_en), 32'h0F);
    check(32'(pad_oe_n[7:4]), 32'hF);
    check(32'(pad_pullup_en[7:4]), 32'h0);
    check(32'(async_rx_data), 32'h0);
    rd_chk(IN_OFS, 32'h0F);
    $display("test analog done");
  endtask

  // reset, then the scenarios in turn
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    por_active = 1'b1;
    pwm0_out = 1'b0;
    pwm1_out = 1'b0;
    async_tx_data = 1'b0;
    sync_line0_is_output = 1'b0;
    sync_line1_is_output = 1'b0;
    ext_en = 8'h00;
    ext_val = 8'h00;
    n_mismatch = 0;
    tests_run = 0;
    repeat (10) @(posedge pclk);
    t_reset;
    t_drive;
    t_func;
    t_serial;
    t_analog;
    summarize;
  end
endmodule
`default_nettype wire
